// >>> rtl/mic_pkg.sv
// package: register map, field layout, vectors and wake classes for the interrupt controller
`default_nettype none
package mic_pkg;
  localparam int unsigned MIC_NSRC      = 14;
  localparam int unsigned MIC_NEXT      = 5;
  // apb byte addresses
  localparam logic [7:0] MIC_ADDR_SENSE_LOW  = 8'h00;
  localparam logic [7:0] MIC_ADDR_SENSE_HIGH = 8'h04;
  localparam logic [7:0] MIC_ADDR_PEND       = 8'h08;
  localparam logic [7:0] MIC_ADDR_STATUS     = 8'h0c;
  localparam logic [7:0] MIC_SENSE_RST       = 8'h00;
  localparam logic [7:0] MIC_SENSE_LOW_MASK  = 8'h3f;
  localparam logic [7:0] MIC_SENSE_HIGH_MASK = 8'h0f;
  // sensitivity encodings
  localparam logic [1:0] MIC_SENSE_FALL_LOW = 2'h0;
  localparam logic [1:0] MIC_SENSE_RISE     = 2'h1;
  localparam logic [1:0] MIC_SENSE_FALL     = 2'h2;
  localparam logic [1:0] MIC_SENSE_BOTH     = 2'h3;
  // vectors
  localparam logic [15:0] MIC_VEC_RESET = 16'hfffe;
  localparam logic [15:0] MIC_VEC_TRAP  = 16'hfffc;
  localparam logic [15:0] MIC_VEC_SRC0  = 16'hfffa;
  localparam logic [15:0] MIC_VEC_STEP  = 16'h0002;
  // source numbers of the auto-wakeup source and the external lines
  localparam int unsigned MIC_SRC_AWU  = 0;
  localparam int unsigned MIC_SRC_EXT0 = 1;
  localparam int unsigned MIC_SRC_EXT1 = 2;
  localparam int unsigned MIC_SRC_EXT2 = 3;
  localparam int unsigned MIC_SRC_EXT3 = 5;
  localparam int unsigned MIC_SRC_EXT4 = 6;
  // wake classes per source (bit n = source n)
  localparam logic [13:0] MIC_WAKE_HALT   = 14'h002e;
  localparam logic [13:0] MIC_WAKE_HALT_WITH_AUTO_WAKEUP  = 14'h002f;
  localparam logic [13:0] MIC_WAKE_ACTIVE = 14'h0a6e;
  // low-power state of the core
  typedef enum logic [3:0] {
    MIC_PM_RUN    = 4'h1,
    MIC_PM_WAIT   = 4'h2,
    MIC_PM_ACTIVE = 4'h4,
    MIC_PM_HALT   = 4'h8
  } mic_pm_t;
  // core sequencer
  typedef enum logic [2:0] {
    MIC_ST_IDLE  = 3'h1,
    MIC_ST_STACK = 3'h2,
    MIC_ST_VEC   = 3'h4
  } mic_state_t;
endpackage : mic_pkg
`default_nettype wire

// >>> rtl/mic_ext_if.sv
// interface: external line sense settings and pending/ack between top and edge detector
`default_nettype none
interface mic_ext_if;
  import mic_pkg::*;
  logic [2*MIC_NEXT-1:0] sense;
  logic [MIC_NEXT-1:0]   sense_chg;
  logic [MIC_NEXT-1:0]   ack;
  logic [MIC_NEXT-1:0]   nand_block;
  logic [MIC_NEXT-1:0]   pend;
  modport ctrl (output sense, output sense_chg, output ack, output nand_block, input pend);
  modport det  (input sense, input sense_chg, input ack, input nand_block, output pend);
endinterface : mic_ext_if
`default_nettype wire

// >>> rtl/mic_ext_detect.sv
// external line edge/level detector with request latches
`default_nettype none
module mic_ext_detect
  import mic_pkg::*;
(
  // clock and reset
  input  wire logic           clk_i,
  input  wire logic           rst_n_i,
  // pins
  input  wire logic [MIC_NEXT-1:0] line_i,
  // control side
  mic_ext_if.det              ext
);
  logic [MIC_NEXT-1:0] prev_r;
  logic [MIC_NEXT-1:0] latch_r;
  logic [MIC_NEXT-1:0] hit;
  logic [MIC_NEXT-1:0] level;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      prev_r  <= '1;
      latch_r <= '0;
    end else begin
      prev_r  <= line_i;
      // a fresh edge wins over ack and over the sense-change clear
      latch_r <= (latch_r & ~ext.ack & ~ext.sense_chg) | hit;
    end
  end

  genvar g;
  generate
    for (g = 0; g < MIC_NEXT; g++) begin : g_line
      logic [1:0] s;
      logic       rise;
      logic       fall;
      assign s    = ext.sense[2*g +: 2];
      assign rise = line_i[g] & ~prev_r[g];
      assign fall = ~line_i[g] & prev_r[g];
      // every sensitivity, rising included, is masked while a nanded input sits low
      assign hit[g] = ~ext.nand_block[g] & (
                      (s == MIC_SENSE_RISE) ? rise :
                      (s == MIC_SENSE_FALL) ? fall :
                      (s == MIC_SENSE_BOTH) ? (rise | fall) :
                      fall);
      assign level[g] = ~ext.nand_block[g] & (s == MIC_SENSE_FALL_LOW) & ~line_i[g];
    end
  endgenerate

  assign ext.pend = latch_r | level;
endmodule : mic_ext_detect
`default_nettype wire

// >>> rtl/mic_intc.sv
// top: interrupt controller with apb sense registers, priority, vectors and wake logic
// Functional notes
// - trap serviced regardless of global mask
// - external vector only when pending and unmasked
// - edge request latched, cleared on service entry
// - low nanded input blocks rising-edge request
// - peripheral flag needs unmasked and enabled
// - peripheral clear by zero write or sequence
// - clear sequence discards pending latched request
// - fixed priority, source 0 highest, 13 lowest
// - two-byte vectors descending from reset
// - halt wake: reset, lines 0-3, awu only halt_with_auto_wakeup
// - active-halt wake for timers and line 4
// - low sense register fields for lines 0-2
// - high sense register fields for lines 3-4
// - sense writes only while mask set
// - changing sense clears that line's pending
// - sense encodings: fall+low, rise, fall, both
// - sense registers reset to zero
// - push context, set mask, load vector
// - mask set after reset
// - return restores context, clears mask
//
// The APB slave port and the register addresses were decided locally.
`default_nettype none
module mic_intc
  import mic_pkg::*;
#(
  parameter int unsigned STACK_CYCLES = 4
) (
  // clock and reset
  input  wire logic                clk_i,
  input  wire logic                resetn_i,
  // apb slave
  input  wire logic                psel_i,
  input  wire logic                penable_i,
  input  wire logic                pwrite_i,
  input  wire logic [7:0]          paddr_i,
  input  wire logic [31:0]         pwdata_i,
  output logic      [31:0]         prdata_o,
  output logic                     pready_o,
  output logic                     pslverr_o,
  // pins and peripherals
  input  wire logic [MIC_NEXT-1:0] ext_line_i,
  input  wire logic [MIC_NEXT-1:0] nand_low_i,
  input  wire logic [MIC_NSRC-1:0] periph_flag_i,
  input  wire logic [MIC_NSRC-1:0] periph_en_i,
  input  wire logic [MIC_NSRC-1:0] periph_wr0_i,
  input  wire logic [MIC_NSRC-1:0] periph_seq_clr_i,
  // core
  input  wire logic                boundary_i,
  input  wire logic                trap_i,
  input  wire logic                return_from_service_instr_i,
  input  wire logic [3:0]          power_mode_i,
  output logic                     irq_o,
  output logic      [15:0]         vector_o,
  output logic                     push_ctx_o,
  output logic                     pop_ctx_o,
  output logic                     mask_o,
  output logic                     wake_o
);
  if (STACK_CYCLES < 1 || STACK_CYCLES > 255) begin : g_bad_cfg
    $error("STACK_CYCLES out of range");
  end

  // reset release through two flops
  logic rst_meta_r;
  logic rst_n_r;
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rst_meta_r <= 1'b0;
      rst_n_r    <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_n_r    <= rst_meta_r;
    end
  end

  // registers
  logic [7:0]          ext_sense_ctrl_low_r;
  logic [7:0]          ext_sense_ctrl_high_r;
  logic [MIC_NSRC-1:0] periph_latch_r;
  logic                mask_r;
  logic [MIC_NSRC-1:0] serving_r;
  logic                trap_serving_r;
  logic [7:0]          cnt_r;
  logic [15:0]         vec_r;
  mic_state_t          state_r;

  // apb decode
  wire wr_en   = psel_i & penable_i & pwrite_i;
  wire hit_lo  = (paddr_i == MIC_ADDR_SENSE_LOW);
  wire hit_hi  = (paddr_i == MIC_ADDR_SENSE_HIGH);
  wire hit_pnd = (paddr_i == MIC_ADDR_PEND);
  wire hit_st  = (paddr_i == MIC_ADDR_STATUS);
  wire mapped  = hit_lo | hit_hi | hit_pnd | hit_st;
  // writes to sense registers land only while masked
  wire wr_lo   = wr_en & hit_lo & mask_r;
  wire wr_hi   = wr_en & hit_hi & mask_r;
  wire [7:0] lo_nxt = pwdata_i[7:0] & MIC_SENSE_LOW_MASK;
  wire [7:0] hi_nxt = pwdata_i[7:0] & MIC_SENSE_HIGH_MASK;

  // external detector
  mic_ext_if ext ();
  assign ext.sense = {ext_sense_ctrl_high_r[3:0], ext_sense_ctrl_low_r[5:0]};
  assign ext.nand_block = nand_low_i;
  genvar g;
  generate
    for (g = 0; g < MIC_NEXT; g++) begin : g_chg
      logic [1:0] new_f;
      logic       wr_f;
      if (g < 3) begin : g_lo
        assign new_f = lo_nxt[2*g +: 2];
        assign wr_f  = wr_lo;
      end else begin : g_hi
        assign new_f = hi_nxt[2*(g-3) +: 2];
        assign wr_f  = wr_hi;
      end
      assign ext.sense_chg[g] = wr_f & (new_f != ext.sense[2*g +: 2]);
    end
  endgenerate

  mic_ext_detect u_det (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_r),
    .line_i  (ext_line_i),
    .ext     (ext)
  );

  // source map of pending requests
  logic [MIC_NSRC-1:0] ext_map;
  always_comb begin
    ext_map = '0;
    ext_map[MIC_SRC_EXT0] = ext.pend[0];
    ext_map[MIC_SRC_EXT1] = ext.pend[1];
    ext_map[MIC_SRC_EXT2] = ext.pend[2];
    ext_map[MIC_SRC_EXT3] = ext.pend[3];
    ext_map[MIC_SRC_EXT4] = ext.pend[4];
  end
  // peripheral latch: a flag held until cleared, pending only while enabled
  wire [MIC_NSRC-1:0] periph_clr = periph_wr0_i | periph_seq_clr_i;
  wire [MIC_NSRC-1:0] periph_pend = periph_latch_r & periph_en_i;
  wire [MIC_NSRC-1:0] pending  = ext_map | periph_pend;
  // read view shows requests still waiting for their enable as well
  wire [MIC_NSRC-1:0] latched  = ext_map | periph_latch_r;
  wire [MIC_NSRC-1:0] eligible = mask_r ? '0 : pending;

  // fixed priority, lowest number wins
  logic [MIC_NSRC-1:0] win;
  logic [15:0]         win_vec;
  always_comb begin
    win     = '0;
    win_vec = MIC_VEC_SRC0;
    for (int i = MIC_NSRC - 1; i >= 0; i--) begin
      if (eligible[i]) begin
        win     = '0;
        win[i]  = 1'b1;
        win_vec = MIC_VEC_SRC0 - 16'(i) * MIC_VEC_STEP;
      end
    end
  end
  wire any_win = |eligible;
  wire take    = (state_r == MIC_ST_IDLE) & boundary_i & (trap_i | any_win);

  // acknowledge of external latches on service entry
  assign ext.ack = {serving_r[MIC_SRC_EXT4], serving_r[MIC_SRC_EXT3],
                    serving_r[MIC_SRC_EXT2], serving_r[MIC_SRC_EXT1],
                    serving_r[MIC_SRC_EXT0]} & {MIC_NEXT{state_r == MIC_ST_VEC}};

  // wake decision by power mode
  wire [MIC_NSRC-1:0] wake_set =
      (power_mode_i == MIC_PM_HALT)   ? MIC_WAKE_HALT :
      (power_mode_i == MIC_PM_ACTIVE) ? MIC_WAKE_ACTIVE :
      (power_mode_i == MIC_PM_WAIT)   ? {MIC_NSRC{1'b1}} :
      (power_mode_i == (MIC_PM_HALT | MIC_PM_WAIT)) ? MIC_WAKE_HALT_WITH_AUTO_WAKEUP : '0;
  wire wake_nxt = |(pending & wake_set);

  // sequencer
  always_ff @(posedge clk_i or negedge rst_n_r) begin
    if (!rst_n_r) begin
      state_r        <= MIC_ST_IDLE;
      mask_r         <= 1'b1;
      serving_r      <= '0;
      trap_serving_r <= 1'b0;
      cnt_r          <= '0;
      vec_r          <= MIC_VEC_RESET;
    end else begin
      unique case (state_r)
        MIC_ST_IDLE: begin
          if (take) begin
            state_r        <= MIC_ST_STACK;
            trap_serving_r <= trap_i;
            serving_r      <= trap_i ? '0 : win;
            vec_r          <= trap_i ? MIC_VEC_TRAP : win_vec;
            cnt_r          <= 8'(STACK_CYCLES - 1);
          end else if (return_from_service_instr_i) begin
            mask_r <= 1'b0;
          end else if (power_mode_i == MIC_PM_WAIT) begin
            mask_r <= 1'b0;
          end
        end
        MIC_ST_STACK: begin
          if (cnt_r == '0) begin
            state_r <= MIC_ST_VEC;
            mask_r  <= 1'b1;
          end else begin
            cnt_r <= cnt_r - 8'h01;
          end
        end
        MIC_ST_VEC: begin
          state_r   <= MIC_ST_IDLE;
          serving_r <= '0;
        end
        default: state_r <= MIC_ST_IDLE;
      endcase
    end
  end

  // registers and outputs
  always_ff @(posedge clk_i or negedge rst_n_r) begin
    if (!rst_n_r) begin
      ext_sense_ctrl_low_r  <= MIC_SENSE_RST;
      ext_sense_ctrl_high_r <= MIC_SENSE_RST;
      periph_latch_r        <= '0;
      prdata_o              <= '0;
      pready_o              <= 1'b0;
      pslverr_o             <= 1'b0;
      irq_o                 <= 1'b0;
      vector_o              <= MIC_VEC_RESET;
      push_ctx_o            <= 1'b0;
      pop_ctx_o             <= 1'b0;
      mask_o                <= 1'b1;
      wake_o                <= 1'b0;
    end else begin
      if (wr_lo) ext_sense_ctrl_low_r <= lo_nxt;
      if (wr_hi) ext_sense_ctrl_high_r <= hi_nxt;
      // new flag wins over clear; clear drops a request still awaiting enable
      periph_latch_r <= (periph_latch_r & ~periph_clr) | periph_flag_i;
      pready_o  <= psel_i & ~penable_i;
      pslverr_o <= psel_i & ~penable_i & ~mapped;
      prdata_o  <= !(psel_i & ~penable_i) ? '0 :
                   hit_lo  ? {24'h0, ext_sense_ctrl_low_r} :
                   hit_hi  ? {24'h0, ext_sense_ctrl_high_r} :
                   hit_pnd ? {18'h0, latched} :
                   hit_st  ? {24'h0, 3'h0, trap_serving_r, state_r, mask_r} : '0;
      irq_o      <= (state_r == MIC_ST_IDLE) & (trap_i | any_win);
      vector_o   <= (state_r == MIC_ST_IDLE) ? (trap_i ? MIC_VEC_TRAP : win_vec) : vec_r;
      push_ctx_o <= take;
      pop_ctx_o  <= (state_r == MIC_ST_IDLE) & ~take & return_from_service_instr_i;
      mask_o     <= mask_r;
      wake_o     <= wake_nxt;
    end
  end
endmodule : mic_intc
`default_nettype wire

// >>> test/mic_intc_assertions.sv
// checker: port-level properties of the interrupt controller
`default_nettype none
module mic_intc_assertions
  import mic_pkg::*;
#(
  parameter int unsigned STACK_CYCLES = 4
) (
  // clock and reset
  input wire logic        clk_i,
  input wire logic        resetn_i,
  // apb
  input wire logic        psel_i,
  input wire logic        penable_i,
  input wire logic        pwrite_i,
  input wire logic [7:0]  paddr_i,
  input wire logic [31:0] prdata_o,
  input wire logic        pready_o,
  input wire logic        pslverr_o,
  // core
  input wire logic        boundary_i,
  input wire logic        trap_i,
  input wire logic        return_from_service_instr_i,
  input wire logic [15:0] vector_o,
  input wire logic        push_ctx_o,
  input wire logic        pop_ctx_o,
  input wire logic        mask_o
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  logic [4:0] since_push_r;
  wire logic  rd_w = pready_o && !pwrite_i;
  wire logic  mapped_w = paddr_i inside {MIC_ADDR_SENSE_LOW, MIC_ADDR_SENSE_HIGH,
                                         MIC_ADDR_PEND, MIC_ADDR_STATUS};
  // cycles since the last service entry, saturating
  always_ff @(posedge clk_i or negedge resetn_i)
    if (!resetn_i) since_push_r <= 5'h1f;
    else if (push_ctx_o) since_push_r <= 5'h00;
    else if (since_push_r != 5'h1f) since_push_r <= since_push_r + 5'h01;
  AST_APB_ANSWER: assert property (psel_i && !penable_i |=> pready_o)
    else $error("no apb answer after setup");
  AST_READY_PULSE: assert property (pready_o |=> !pready_o)
    else $error("pready longer than one cycle");
  AST_ERR_UNMAPPED: assert property (pready_o |-> pslverr_o == !mapped_w)
    else $error("slave error does not match address map");
  AST_LOW_RSVD: assert property (rd_w && paddr_i == MIC_ADDR_SENSE_LOW |-> prdata_o[31:6] == 26'h0)
    else $error("reserved sense low bits read nonzero");
  AST_HIGH_RSVD: assert property (rd_w && paddr_i == MIC_ADDR_SENSE_HIGH |-> prdata_o[31:4] == 28'h0)
    else $error("reserved sense high bits read nonzero");
  AST_PUSH_CAUSE: assert property (push_ctx_o |-> $past(boundary_i) && ($past(trap_i) || !$past(mask_o)))
    else $error("service entered without cause");
  AST_PUSH_MASK: assert property (since_push_r == 5'(STACK_CYCLES + 1) |-> mask_o)
    else $error("mask not set after service entry");
  AST_POP_CAUSE: assert property (pop_ctx_o |-> $past(return_from_service_instr_i) ##[0:1] !mask_o)
    else $error("return did not restore mask");
  AST_VEC_RANGE: assert property (vector_o[0] == 1'b0 && vector_o >= 16'hffe0)
    else $error("vector outside table");
  cover property (push_ctx_o && vector_o == MIC_VEC_TRAP);
  cover property (pop_ctx_o);
  cover property (pready_o && pslverr_o);
endmodule // mic_intc_assertions
bind mic_intc mic_intc_assertions #(.STACK_CYCLES(STACK_CYCLES)) mic_intc_assertions_inst (
  .clk_i(clk_i), .resetn_i(resetn_i), .psel_i(psel_i), .penable_i(penable_i),
  .pwrite_i(pwrite_i), .paddr_i(paddr_i), .prdata_o(prdata_o), .pready_o(pready_o),
  .pslverr_o(pslverr_o), .boundary_i(boundary_i), .trap_i(trap_i),
  .return_from_service_instr_i(return_from_service_instr_i), .vector_o(vector_o),
  .push_ctx_o(push_ctx_o), .pop_ctx_o(pop_ctx_o), .mask_o(mask_o));
`default_nettype wire

// >>> test/mic_core_model.sv
// partner: core model issuing instruction boundaries and returns
`default_nettype none
module mic_core_model (
  // clock and reset
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  // controller side
  input  wire logic push_i,
  input  wire logic halted_i,
  input  wire logic ret_req_i,
  output logic      boundary_o,
  output logic      ret_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [2:0] cnt_r;
  logic       isr_r;
  // a halted core executes nothing, so no boundary is offered
  wire logic  slot_w = cnt_r == 3'h7 && !halted_i;
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_r <= 3'h0;
      isr_r <= 1'b0;
      boundary_o <= 1'b0;
      ret_o <= 1'b0;
    end else begin
      cnt_r <= cnt_r + 3'h1;
      boundary_o <= slot_w && !ret_req_i && !isr_r;
      ret_o <= slot_w && ret_req_i;
      if (push_i) isr_r <= 1'b1;
      else if (ret_o) isr_r <= 1'b0;
    end
  end
endmodule // mic_core_model
`default_nettype wire

// >>> test/mic_intc_tb_top.sv
// testbench: apb master, pins and peripherals around the interrupt controller
`default_nettype none
module mic_intc_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import mic_pkg::*;
  logic clk_i = 1'b0, resetn_i = 1'b0, psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
  logic trap_i = 1'b0, ret_req = 1'b0, boundary_i, ret_i, pready_o, pslverr_o;
  logic irq_o, push_ctx_o, pop_ctx_o, mask_o, wake_o;
  logic [7:0] paddr_i = 8'h00;
  logic [31:0] pwdata_i = 32'h0, prdata_o;
  logic [4:0] ext_line_i = 5'h1f, nand_low_i = 5'h00;
  logic [13:0] periph_flag_i = 14'h0, periph_en_i = 14'h0, periph_wr0_i = 14'h0;
  logic [13:0] periph_seq_clr_i = 14'h0;
  logic [3:0] power_mode_i = 4'h1;
  logic [15:0] vector_o;
  int n_mismatch = 0, check_count = 0;
  mic_intc #(.STACK_CYCLES(2)) mic_intc_inst (.clk_i(clk_i), .resetn_i(resetn_i),
    .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
    .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
    .ext_line_i(ext_line_i), .nand_low_i(nand_low_i), .periph_flag_i(periph_flag_i),
    .periph_en_i(periph_en_i), .periph_wr0_i(periph_wr0_i),
    .periph_seq_clr_i(periph_seq_clr_i), .boundary_i(boundary_i), .trap_i(trap_i),
    .return_from_service_instr_i(ret_i), .power_mode_i(power_mode_i), .irq_o(irq_o),
    .vector_o(vector_o), .push_ctx_o(push_ctx_o), .pop_ctx_o(pop_ctx_o), .mask_o(mask_o),
    .wake_o(wake_o));
  mic_core_model mic_core_model_inst (.clk_i(clk_i), .rst_n_i(resetn_i), .push_i(push_ctx_o),
    .halted_i(power_mode_i != 4'h1), .ret_req_i(ret_req), .boundary_o(boundary_i),
    .ret_o(ret_i));
  always #50 clk_i = ~clk_i;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clk_i);
    penable_i <= 1'b1;
    do @(posedge clk_i); while (pready_o !== 1'b1);
    r = prdata_o;
    e = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    chk(r, exp);
    chk(32'(e), 32'(!(a inside {MIC_ADDR_SENSE_LOW, MIC_ADDR_SENSE_HIGH,
                                MIC_ADDR_PEND, MIC_ADDR_STATUS})));
  endtask
  task automatic pulse(input int k, input logic [13:0] v);
    case (k)
      0: periph_flag_i <= v;
      1: periph_wr0_i <= v;
      default: periph_seq_clr_i <= v;
    endcase
    @(posedge clk_i);
    periph_flag_i <= 14'h0;
    periph_wr0_i <= 14'h0;
    periph_seq_clr_i <= 14'h0;
    @(posedge clk_i);
  endtask
  task automatic rise0();
    ext_line_i <= 5'h1e;
    @(posedge clk_i);
    ext_line_i <= 5'h1f;
  endtask
  task automatic expect_push(input logic exp, input logic [15:0] vec);
    logic got;
    logic [15:0] v;
    got = 1'b0;
    repeat (24) if (!got) begin
      @(posedge clk_i);
      got = push_ctx_o === 1'b1;
      v = vector_o;
    end
    chk(32'(got), 32'(exp));
    if (exp) chk(32'(v), 32'(vec));
  endtask
  task automatic ret_isr();
    logic got;
    got = 1'b0;
    ret_req <= 1'b1;
    repeat (40) if (!got) begin
      @(posedge clk_i);
      got = pop_ctx_o === 1'b1;
    end
    ret_req <= 1'b0;
    @(posedge clk_i);
    chk({30'h0, got, mask_o}, 32'h2);
  endtask
  task automatic t_regs();
    logic [31:0] d;
    for (int c = 0; c < 4; c++) begin
      d = {26'h0, 2'(c), 2'(c), 2'(c)};
      wr(MIC_ADDR_SENSE_LOW, d);
      rd(MIC_ADDR_SENSE_LOW, d);
    end
    wr(MIC_ADDR_SENSE_LOW, 32'hff);
    rd(MIC_ADDR_SENSE_LOW, 32'h3f);
    wr(MIC_ADDR_SENSE_HIGH, 32'hff);
    rd(MIC_ADDR_SENSE_HIGH, 32'h0f);
    wr(MIC_ADDR_SENSE_LOW, 32'h01);
    wr(MIC_ADDR_SENSE_HIGH, 32'h04);
    rd(8'h10, 32'h0);
  endtask
  task automatic t_ext();
    wr(MIC_ADDR_SENSE_LOW, 32'h3f);
    rd(MIC_ADDR_SENSE_LOW, 32'h01);
    nand_low_i <= 5'h01;
    rise0();
    expect_push(1'b0, 16'h0);
    nand_low_i <= 5'h00;
    rise0();
    expect_push(1'b1, 16'hfff8);
    // the latch is acknowledged only once the context push is over
    repeat (4) @(posedge clk_i);
    rd(MIC_ADDR_PEND, 32'h0);
    wr(MIC_ADDR_SENSE_LOW, 32'h02);
    rise0();
    rd(MIC_ADDR_PEND, 32'h2);
    wr(MIC_ADDR_SENSE_LOW, 32'h01);
    rd(MIC_ADDR_PEND, 32'h0);
    ret_isr();
  endtask
  task automatic t_periph();
    pulse(0, 14'h0200);
    expect_push(1'b0, 16'h0);
    chk(32'(irq_o), 32'h0);
    rd(MIC_ADDR_PEND, 32'h0200);
    pulse(2, 14'h0200);
    rd(MIC_ADDR_PEND, 32'h0);
    pulse(0, 14'h0400);
    pulse(1, 14'h0400);
    rd(MIC_ADDR_PEND, 32'h0);
    periph_en_i <= 14'h0880;
    pulse(0, 14'h0880);
    expect_push(1'b1, 16'hffec);
    pulse(1, 14'h0080);
    ret_isr();
    expect_push(1'b1, 16'hffe4);
    pulse(1, 14'h0800);
    ret_isr();
  endtask
  task automatic t_wake();
    power_mode_i <= MIC_PM_HALT;
    pulse(0, 14'h0800);
    repeat (4) @(posedge clk_i);
    chk(32'(wake_o), 32'h0);
    chk(32'(irq_o), 32'h1);
    power_mode_i <= MIC_PM_HALT | MIC_PM_WAIT;
    repeat (4) @(posedge clk_i);
    chk(32'(wake_o), 32'h0);
    power_mode_i <= MIC_PM_WAIT;
    repeat (4) @(posedge clk_i);
    chk(32'(wake_o), 32'h1);
    power_mode_i <= MIC_PM_ACTIVE;
    repeat (4) @(posedge clk_i);
    chk(32'(wake_o), 32'h1);
    power_mode_i <= MIC_PM_HALT;
    rise0();
    repeat (4) @(posedge clk_i);
    chk(32'(wake_o), 32'h1);
    power_mode_i <= MIC_PM_RUN;
    expect_push(1'b1, 16'hfff8);
    ret_isr();
    expect_push(1'b1, 16'hffe4);
    pulse(1, 14'h0800);
    ret_isr();
  endtask
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge clk_i);
    chk({15'h0, mask_o, vector_o}, {15'h0, 1'b1, MIC_VEC_RESET});
    resetn_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    rd(MIC_ADDR_SENSE_LOW, 32'h0);
    rd(MIC_ADDR_SENSE_HIGH, 32'h0);
    t_regs();
    trap_i <= 1'b1;
    expect_push(1'b1, MIC_VEC_TRAP);
    trap_i <= 1'b0;
    ret_isr();
    t_ext();
    t_periph();
    t_wake();
    tally_and_finish();
  end
  initial begin
    repeat (20000) @(posedge clk_i);
    n_mismatch++;
    tally_and_finish();
  end
endmodule // mic_intc_tb_top
`default_nettype wire
